//--- pkg/sarp_cfg.svh
// Constants of the serial readout port: edge counts and output codes.
// Assumes inclusion by bare name from the package; the design files use its macros without including it.
`ifndef SARP_CFG_SVH
`define SARP_CFG_SVH

`define SARP_DATA_BITS   16
`define SARP_EDGE_W      5
`define SARP_LEAD_EDGES  5'd5
`define SARP_LAST_EDGE   5'd21
`define SARP_EDGE_SAT    5'h1f
`define SARP_CODE_MAX    16'h7fff
`define SARP_CODE_MID    16'h0000
`define SARP_CODE_MIN    16'h8000
`define SARP_CS_IDLE     1'b1
`define SARP_PD_RESET    1'b1

`endif

//--- pkg/sarp_pkg.sv
// Types of the serial readout port: core state and link state.
// Assumes sarp_cfg.svh is on the include path.
`include "sarp_cfg.svh"

package sarp_pkg;

	typedef enum logic {
		sarp_track,
		sarp_convert
	} sarp_core_state_e;

	typedef struct packed {
		sarp_core_state_e             st;
		logic                         cs_prev;
		logic                         pd;
		logic [`SARP_DATA_BITS-1:0]   code;
	} sarp_core_s;

	typedef struct packed {
		logic [`SARP_EDGE_W-1:0]      edges;
		logic [`SARP_DATA_BITS-1:0]   sar;
		logic                         dout;
		logic                         oe_n;
		logic                         done;
	} sarp_link_s;

endpackage

//--- verilog/sarp_sync.sv
// Two-flop level synchroniser, one lane per bit.
// Assumes each input bit is a level that holds for several destination clocks.
`timescale 1ns/1ns
`default_nettype none

module sarp_sync #(
	parameter int               W       = 2,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic [W-1:0]   d_i,
	output logic      [W-1:0]   q_o
);

	generate
		if (W < 1) begin : g_bad_w
			$error("sarp_sync width must be at least one");
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_lane
			logic meta_r;
			logic stab_r;
			// First flop feeds only the second
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_r <= RST_VAL[gi];
					stab_r <= RST_VAL[gi];
				end else begin
					meta_r <= d_i[gi];
					stab_r <= meta_r;
				end
			end
			assign q_o[gi] = stab_r;
		end
	endgenerate

endmodule // sarp_sync

`default_nettype wire

//--- verilog/sarp_port.sv
// Serial readout port of a 16-bit differential successive-approximation converter.
// Assumes the host keeps select low a few core clocks before the first serial clock fall.
`timescale 1ns/1ns
`default_nettype none

module sarp_port
	import sarp_pkg::*;
#(
	parameter int                       IN_W = 18
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	input  wire logic signed [IN_W-1:0] analog_level_i,
	input  wire logic                   select_n_i,
	input  wire logic                   serial_clock_i,
	output logic                        dout_o,
	output logic                        dout_oe_n_o,
	output logic                        powered_down_o
);

	generate
		if (IN_W < `SARP_DATA_BITS + 1) begin : g_bad_in_w
			$error("sarp_port input must be wider than the result to show over-range");
		end
	endgenerate

	localparam logic signed [IN_W-1:0] LIM_HI = {{(IN_W-`SARP_DATA_BITS){1'b0}}, `SARP_CODE_MAX};
	localparam logic signed [IN_W-1:0] LIM_LO = {{(IN_W-`SARP_DATA_BITS){1'b1}}, `SARP_CODE_MIN};

	sarp_core_s                 core_r;
	sarp_core_s                 core_nxt;
	sarp_link_s                 link_r;
	sarp_link_s                 link_nxt;
	logic [1:0]                 sync_q;
	logic                       cs_s;
	logic                       done_s;
	logic                       link_rst;
	logic [`SARP_DATA_BITS-1:0] clamped;
	logic                       over_rng;
	logic                       under_rng;

	// Select and link-done cross into the core clock as levels
	sarp_sync #(
		.W       (2),
		.RST_VAL ({1'b0, `SARP_CS_IDLE})
	) u_sync (
		.clk_i (core_clk_i),
		.rst_i (rst_i),
		.d_i   ({link_r.done, select_n_i}),
		.q_o   (sync_q)
	);

	assign cs_s   = sync_q[0];
	assign done_s = sync_q[1];

	// Over- and under-range saturate instead of wrapping
	always_comb begin
		over_rng  = analog_level_i > LIM_HI;
		under_rng = analog_level_i < LIM_LO;
		if (over_rng) begin
			clamped = `SARP_CODE_MAX;
		end else if (under_rng) begin
			clamped = `SARP_CODE_MIN;
		end else begin
			clamped = analog_level_i[`SARP_DATA_BITS-1:0];
		end
	end

	// Core side: track, hold and power control
	always_comb begin
		core_nxt         = core_r;
		core_nxt.cs_prev = cs_s;
		case (core_r.st)
			sarp_track: begin
				// Track only while select idles, so a finished word stays put until select rises
				if (cs_s) begin
					core_nxt.code = clamped;
				end
				if (core_r.cs_prev && !cs_s) begin
					core_nxt.st = sarp_convert;
					core_nxt.pd = 1'b0;
				end
			end
			sarp_convert: begin
				// Held word frozen for the whole frame
				if (done_s || cs_s) begin
					core_nxt.st = sarp_track;
					core_nxt.pd = 1'b1;
				end
			end
			default: begin
				core_nxt.st = sarp_track;
				core_nxt.pd = `SARP_PD_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			core_r <= '{st: sarp_track, cs_prev: `SARP_CS_IDLE, pd: `SARP_PD_RESET, code: `SARP_CODE_MID};
		end else begin
			core_r <= core_nxt;
		end
	end

	// Link side: select high is the frame's own reset, so no serial clock is needed to release
	assign link_rst = rst_i | select_n_i;

	always_comb begin
		logic [`SARP_EDGE_W-1:0]     nth;
		logic [3:0]                  bidx;
		logic [`SARP_DATA_BITS-1:0]  offs;
		logic [`SARP_DATA_BITS-1:0]  trial;
		logic                        keep;
		nth   = '0;
		bidx  = '0;
		offs  = '0;
		trial = '0;
		keep  = 1'b0;
		link_nxt = link_r;
		if (link_r.edges != `SARP_EDGE_SAT) begin
			link_nxt.edges = link_r.edges + 5'd1;
		end
		nth = link_r.edges + 5'd1;
		// Offset binary lets the search compare unsigned
		offs = {~core_r.code[`SARP_DATA_BITS-1], core_r.code[`SARP_DATA_BITS-2:0]};
		if (nth == `SARP_LEAD_EDGES) begin
			link_nxt.oe_n = 1'b0;
			link_nxt.dout = 1'b0;
		end else if (nth > `SARP_LEAD_EDGES && nth <= `SARP_LAST_EDGE) begin
			// One decision per falling edge, most significant first
			bidx  = 4'(`SARP_LAST_EDGE - nth);
			trial = link_r.sar | (16'h0001 << bidx);
			keep  = offs >= trial;
			link_nxt.sar  = keep ? trial : link_r.sar;
			link_nxt.dout = (bidx == 4'hf) ? ~keep : keep;
			if (nth == `SARP_LAST_EDGE) begin
				link_nxt.done = 1'b1;
			end
		end else if (nth > `SARP_LAST_EDGE) begin
			link_nxt.dout = 1'b0;
		end
	end

	// Launch on falling edges only, so each bit spans the next rise and fall
	always_ff @(negedge serial_clock_i or posedge link_rst) begin
		if (link_rst) begin
			link_r <= '{edges: '0, sar: '0, dout: 1'b0, oe_n: 1'b1, done: 1'b0};
		end else begin
			link_r <= link_nxt;
		end
	end

	assign dout_o         = link_r.dout;
	assign dout_oe_n_o    = link_r.oe_n;
	assign powered_down_o = core_r.pd;

	start_conv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(core_r.st == sarp_track && core_r.cs_prev && !cs_s) |=> (core_r.st == sarp_convert && !powered_down_o))
		else $error("select fall did not start a conversion");

	lead_quiet_a: assert property (@(negedge serial_clock_i) disable iff (link_rst)
		(link_r.edges < `SARP_LEAD_EDGES) |-> dout_oe_n_o)
		else $error("output enabled before the fifth falling edge");

	lead_low_a: assert property (@(negedge serial_clock_i) disable iff (link_rst)
		(link_r.edges == `SARP_LEAD_EDGES) |-> (!dout_oe_n_o && !dout_o))
		else $error("output not driven low at fifth falling edge");

	msb_first_a: assert property (@(negedge serial_clock_i) disable iff (link_rst)
		(link_r.edges > `SARP_LEAD_EDGES && link_r.edges <= `SARP_LAST_EDGE)
		|-> (!dout_oe_n_o && dout_o == core_r.code[4'(`SARP_LAST_EDGE - link_r.edges)]))
		else $error("wrong result bit at falling edge");

	rise_valid_a: assert property (@(posedge serial_clock_i) disable iff (link_rst)
		(link_r.edges > `SARP_LEAD_EDGES && link_r.edges <= `SARP_LAST_EDGE)
		|-> (dout_o == core_r.code[4'(`SARP_LAST_EDGE - link_r.edges)]))
		else $error("result bit not valid at rising edge");

	power_down_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(core_r.st == sarp_convert && (done_s || cs_s)) |=> (powered_down_o && core_r.st == sarp_track))
		else $error("no power down after conversion");

	clamp_hi_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(core_r.st == sarp_track && cs_s && over_rng) |=> (core_r.code == `SARP_CODE_MAX))
		else $error("over-range not clamped");

	clamp_lo_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(core_r.st == sarp_track && cs_s && under_rng) |=> (core_r.code == `SARP_CODE_MIN))
		else $error("under-range not clamped");

	held_word_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(!cs_s && !$past(cs_s)) |-> $stable(core_r.code))
		else $error("held word changed during a frame");

	release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		select_n_i |-> (dout_oe_n_o && link_r.edges == '0))
		else $error("output not released while select high");

	frame_done_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
		core_r.st == sarp_convert ##1 done_s);
	over_rng_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
		cs_s && over_rng);
	under_rng_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
		cs_s && under_rng);
	early_abort_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
		core_r.st == sarp_convert && cs_s && !done_s);

endmodule // sarp_port

`default_nettype wire

//--- dv/sarp_host_model.sv
// Host serial port model: frames select, runs the serial clock, captures data.
// Assumes start_i rises only while the previous frame is over.
`timescale 1ns/1ns
`default_nettype none
module sarp_host_model (
	input  wire logic       start_i,
	input  wire logic [4:0] falls_i,
	input  wire logic       dout_i,
	input  wire logic       oe_n_i,
	output logic            select_n_o,
	output logic            sclk_o,
	output logic [16:0]     word_o,
	output logic            ok_o,
	output logic            done_o
);
	logic line;
	logic last;
	int   k;
	initial begin
		select_n_o = 1'b1;
		sclk_o     = 1'b1;
		word_o     = '0;
		ok_o       = 1'b1;
		done_o     = 1'b0;
		last       = 1'b0;
	end
	// Released line shows the inverse of its last value, never a stale copy
	assign line = oe_n_i ? ~last : dout_i;
	always @(posedge start_i) begin
		ok_o       = 1'b1;
		select_n_o = 1'b0;
		#40;
		for (k = 1; k <= falls_i; k++) begin
			sclk_o = 1'b0;
			#3;
			sclk_o = 1'b1;
			if (k < 5 && oe_n_i !== 1'b1) ok_o = 1'b0;
			if (k >= 5 && k <= 21) word_o = {word_o[15:0], line};
			last = line;
			#3;
			if (k >= 5 && line !== last) ok_o = 1'b0;
		end
		if (falls_i >= 5'd21) begin
			done_o = 1'b1;
			#1;
			done_o = 1'b0;
		end
		select_n_o = 1'b1;
		#40;
	end
endmodule // sarp_host_model
`default_nettype wire

//--- dv/tb_serial_adc_readout_port.sv
// Bench of the serial readout port: host model at the link, queued expectations.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_adc_readout_port;
	import sarp_pkg::*;
	logic               core_clk_i = 1'b0;
	logic               rst_i      = 1'b1;
	logic               start      = 1'b0;
	logic signed [17:0] level      = '0;
	logic [4:0]         falls      = 5'd21;
	logic [31:0]        rng        = 32'h7a3f;
	logic [16:0]        exp_q[$];
	logic signed [17:0] lv_t[7]    = '{18'sd32767, -18'sd32768, 18'sd0, 18'sd40000, -18'sd40000, -18'sd1, 18'sd1};
	int                 num_errors = 0;
	int                 samples_checked = 0;
	wire logic          sel_n, sclk, dout, oe_n, pd, ok, done;
	wire logic [16:0]   word;
	always #5 core_clk_i = ~core_clk_i;
	sarp_port u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .analog_level_i(level), .select_n_i(sel_n),
		.serial_clock_i(sclk), .dout_o(dout), .dout_oe_n_o(oe_n), .powered_down_o(pd));
	sarp_host_model u_host (.start_i(start), .falls_i(falls), .dout_i(dout), .oe_n_i(oe_n),
		.select_n_o(sel_n), .sclk_o(sclk), .word_o(word), .ok_o(ok), .done_o(done));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_sim();
		$display("checked=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	always @(posedge done) check({ok, word}, {1'b1, exp_q.pop_front()});
	task frame(input logic signed [17:0] lv, input logic [4:0] n);
		int i;
		@(posedge core_clk_i);
		#1;
		level = lv;
		falls = n;
		if (n >= 5'd21) exp_q.push_back({1'b0, lv > 32767 ? 16'h7fff : lv < -32768 ? 16'h8000 : lv[15:0]});
		repeat (2) @(posedge core_clk_i);
		#1;
		start = 1'b1;
		repeat (6) @(posedge core_clk_i);
		#1;
		start = 1'b0;
		level = ~lv; // A later input must not reach this word
		check(pd, 1'b0);
		for (i = 0; i < 100 && sel_n !== 1'b1; i++) @(posedge core_clk_i);
		#1;
		if (i == 100) begin
			num_errors++;
			end_sim();
		end
		check({oe_n, dout}, 2'b10);
		repeat (5) @(posedge core_clk_i);
		#1;
		check(pd, 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
		check({oe_n, dout, pd}, 3'b101);
		foreach (lv_t[j]) frame(lv_t[j], 5'd21);
		frame(18'sd12, 5'd10);
		frame(18'sd99, 5'd24);
		repeat (20) begin
			rng = xs(rng);
			frame($signed(rng[17:0]), 5'd21 + 5'(rng[20:18]));
		end
		repeat (10) @(posedge core_clk_i);
		check(exp_q.size(), 0);
		end_sim();
	end
endmodule // tb_serial_adc_readout_port
`default_nettype wire
